// ---- verification/packet_buffer_alloc_rx_queue_tb.sv ----
// Self-checking bench for the packet buffer manager.
// Drives APB itself; the receive engine model feeds receptions.
`timescale 1ns/1ps
`default_nettype none
module packet_buffer_alloc_rx_queue_tb
    import pbuf_pkg::*;
;
    typedef struct {logic [7:0] a; logic [32:0] e; logic [32:0] m;} note_t;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, rb;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, rxv, rxr, bv, br, irq;
    rx_info_t ri;
    int fail_count = 0, checks_done = 0, irqs = 0, cyc = 0;
    note_t nq[$];
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    packet_memory_manager uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_rx_valid(rxv), .i_rx_info(ri), .o_rx_ready(rxr), .i_rx_byte_valid(bv),
        .i_rx_byte(rb), .o_rx_byte_ready(br), .o_rx_irq(irq));
    rx_engine_model rxm (.i_core_clk(clk), .i_ready(rxr), .i_byte_ready(br), .o_valid(rxv), .o_info(ri),
        .o_byte_valid(bv), .o_byte(rb));
    task stop_test;
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [32:0] e, input logic [32:0] g, input logic [32:0] m);
        checks_done++;
        if ((g & m) !== (e & m))
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e & m, g & m);
        end
    endtask : chk
    always @(negedge clk)
    begin
        if (irq === 1'b1)
            irqs++;
        if (psel && penable && pready === 1'b1 && !pwrite && nq.size() > 0)
        begin
            note_t t;
            t = nq.pop_front();
            chk($sformatf("reg %h", t.a), t.e, {pslverr, prdata}, t.m);
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Pready and read data are taken at the completing rising edge
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 100);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("wait", 33'h0, 33'(n > SEQ_CYC), 33'h1);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff, input logic err = 0);
        note_t t;
        logic [31:0] r;
        t.a = a;
        t.e = {err, 24'h0, e};
        t.m = {1'b1, {24{|m}}, m};
        nq.push_back(t);
        apb(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic wait_alloc(output logic [4:0] pn);
        logic [31:0] r;
        int t0;
        t0 = cyc;
        do apb(1'b0, OFF_ARR, 32'h0, r); while (r[ARR_FAIL_BIT] !== 1'b0 && cyc - t0 < 2000);
        chk("alloc time", 33'h0, 33'(cyc - t0 > ALLOC_CYC + 8), 33'h1);
        pn = r[4:0];
    endtask : wait_alloc
    task automatic alloc(input logic [3:0] np1, output logic [4:0] pn);
        wr(OFF_CMD, {24'h0, OP_ALLOC, 1'b0, np1});
        wait_alloc(pn);
    endtask : alloc
    task automatic hdr(input logic [7:0] ph, input rx_info_t i, input logic [7:0] b0, m0, base);
        wr(OFF_PLO, 32'h0);
        wr(OFF_PHI, {24'h0, ph});
        rd(OFF_DATA, b0, m0);
        rd(OFF_DATA, i.frame[7:0]);
        rd(OFF_DATA, {5'h0, i.frame[10:8]});
        wr(OFF_PLO, 32'h6);
        wr(OFF_PHI, {24'h0, ph});
        rd(OFF_DATA, i.count[7:0]);
        rd(OFF_DATA, {5'h0, i.count[10:8]});
        for (int k = 0; k < int'(i.count); k++)
            rd(OFF_DATA, base + k[7:0]);
    endtask : hdr
    initial
    begin
        #2000000;
        fail_count++;
        stop_test;
    end
    initial
    begin
        logic [31:0] r;
        logic [4:0] pa, pb, p1, pd[3];
        logic [7:0] b1, b2;
        logic t;
        rx_info_t i1, i2;
        void'($urandom(6828));
        t = 1'($urandom);
        b1 = 8'($urandom);
        b2 = 8'($urandom);
        i1 = {4'h3, t, 1'b1, 11'($urandom), 11'd5};
        i2 = {4'h3, t, 1'b0, 11'($urandom), 11'd4};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_MASK, MASK_RESET);
        chk("rx idle", 33'h2, {31'h0, rxr, br}, 33'h3);
        rd(OFF_ARR, 8'h0, 8'h80);
        rd(OFF_RXQ, 8'h80, 8'h80);
        rd(8'h20, 8'h0, 8'h0, 1'b1);
        alloc(4'h1, pa);
        alloc(4'h0, pb);
        chk("handles", 33'h0, 33'(pa == pb), 33'h1);
        wr(OFF_PNR, {27'h0, pa});
        wr(OFF_PLO, 32'h6);
        wr(OFF_PHI, 32'h40);
        for (int k = 0; k < 3; k++)
            wr(OFF_DATA, 32'((k + 1) * 17));
        wr(OFF_PLO, 32'h6);
        wr(OFF_PHI, 32'h60);
        for (int k = 0; k < 3; k++)
            rd(OFF_DATA, 8'((k + 1) * 17));
        rxm.send(i1, b1);
        repeat (4) @(posedge clk);
        chk("irq masked", 33'h0, 33'(irqs), 33'h1ffffffff);
        wr(OFF_MASK, 32'h0);
        rxm.send(i2, b2);
        repeat (4) @(posedge clk);
        chk("irq", 33'h1, 33'(irqs), 33'h1ffffffff);
        rd(OFF_RXQ, 8'h0, 8'h80);
        apb(1'b0, OFF_RXQ, 32'h0, r);
        p1 = r[4:0];
        hdr(8'he0, i1, 8'h83, 8'h8f, b1);
        wr(OFF_CMD, {24'h0, OP_POP, 5'h0});
        hdr(8'he0, i2, {3'b001, t, 4'h3}, 8'hbf, b2);
        wr(OFF_PNR, {27'h0, p1});
        hdr(8'h60, i1, 8'h83, 8'h8f, b1);
        wr(OFF_CMD, {24'h0, OP_POPFREE, 5'h0});
        rd(OFF_RXQ, 8'h80, 8'h80);
        wr(OFF_CMD, {24'h0, OP_FREE, 5'h0});
        wr(OFF_PNR, {27'h0, pa});
        wr(OFF_CMD, {24'h0, OP_FREE, 5'h0});
        wr(OFF_PNR, {27'h0, pb});
        wr(OFF_CMD, {24'h0, OP_FREE, 5'h0});
        for (int k = 0; k < 3; k++)
            alloc(4'h9, pd[k]);
        wr(OFF_CMD, {24'h0, OP_ALLOC, 5'h2});
        repeat (2) rd(OFF_ARR, 8'h80, 8'h80);
        wr(OFF_PNR, {27'h0, pd[0]});
        wr(OFF_CMD, {24'h0, OP_FREE, 5'h0});
        wait_alloc(p1);
        rd(OFF_ARR, 8'h0, 8'h80);
        stop_test;
    end
endmodule : packet_buffer_alloc_rx_queue_tb
`default_nettype wire

// ---- verification/rx_engine_model.sv ----
// Receive engine model: one descriptor, then exactly count payload bytes.
// Assumes registered ready levels from the manager on the core clock.
`timescale 1ns/1ps
`default_nettype none
module rx_engine_model
    import pbuf_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_ready,
    input wire logic i_byte_ready,
    output logic o_valid,
    output rx_info_t o_info,
    output logic o_byte_valid,
    output logic [7:0] o_byte
);
    initial
    begin
        o_valid = 1'b0;
        o_info = '0;
        o_byte_valid = 1'b0;
        o_byte = 8'h00;
    end
    task automatic send(input rx_info_t info, input logic [7:0] base);
        @(posedge i_core_clk);
        o_valid <= 1'b1;
        o_info <= info;
        do @(negedge i_core_clk); while (!i_ready);
        @(posedge i_core_clk);
        o_valid <= 1'b0;
        // Released lines carry garbage, never the old value
        o_info <= ~info;
        for (int k = 0; k < int'(info.count); k++)
        begin
            if ($urandom % 3 == 0)
            begin
                o_byte_valid <= 1'b0;
                o_byte <= ~o_byte;
                @(posedge i_core_clk);
            end
            o_byte_valid <= 1'b1;
            o_byte <= base + 8'(k);
            do @(negedge i_core_clk); while (!i_byte_ready);
            @(posedge i_core_clk);
        end
        o_byte_valid <= 1'b0;
        o_byte <= ~o_byte;
    endtask : send
endmodule : rx_engine_model
`default_nettype wire

// ---- verilog/packet_memory_manager.sv ----
// Packet buffer manager: page allocator, receive queue and byte window.
// Assumes an APB master on the core clock and a receive engine that
// hands over one descriptor, then its payload bytes, per packet.
`timescale 1ns/1ps
`default_nettype none
module packet_memory_manager
    import pbuf_pkg::*;
#(
    parameter int NPAGES = PAGES,
    parameter int PBYTES = PAGE_BYTES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_rx_valid,
    input wire rx_info_t i_rx_info,
    output logic o_rx_ready,
    input wire logic i_rx_byte_valid,
    input wire logic [7:0] i_rx_byte,
    output logic o_rx_byte_ready,
    output logic o_rx_irq
);
    localparam int seq_lim = SEQ_CYC;
    localparam int pnr_lim = PNR_CYC;
    localparam int alloc_lim = ALLOC_CYC;

    logic [7:0] mem [0:NPAGES*PBYTES-1];
    logic [4:0] pg_tab [0:31][0:9];
    logic [4:0] npg_q [0:31];
    logic [4:0] rxq [0:31];
    logic [31:0] free_q, used_q;
    logic [5:0] qh_q, qt_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [4:0] pnr_q, arr_pn_q;
    logic fail_q, mcu_pend_q;
    logic [4:0] mcu_need_q;
    logic [7:0] mask_q, plo_q;
    logic [10:0] ptr_q;
    logic sel_head_q, auto_q, dir_read_q;
    logic [7:0] rd_q;
    logic [11:0] rd_addr_q;
    logic mem_we_q;
    alloc_state_t a_state_q;
    logic a_rx_q;
    logic [4:0] a_need_q, a_cnt_q, a_pn_q;
    rx_state_t r_state_q;
    rx_info_t r_info_q;
    logic r_last_q, r_same_q;
    logic [15:0] tog_q;
    logic [4:0] r_need_q, r_pn_q;
    logic [2:0] r_idx_q;
    logic [10:0] r_off_q, r_rem_q;
    logic rx_rdy_q, byte_rdy_q, irq_q;

    function automatic logic [4:0] low_one(input logic [31:0] v);
        low_one = 5'd0;
        for (int i = 31; i >= 0; i--)
        begin
            if (v[i])
                low_one = i[4:0];
        end
    endfunction : low_one

    function automatic logic [5:0] ones(input logic [31:0] v);
        ones = 6'd0;
        for (int i = 0; i < 32; i++)
            ones = ones + {5'd0, v[i]};
    endfunction : ones

    // Handles index a page table, so the address is never the handle itself
    function automatic logic [11:0] mem_addr(input logic [4:0] pn, input logic [10:0] off);
        logic [3:0] ix;
        ix = (off[10:7] > 4'd9) ? 4'd9 : off[10:7];
        mem_addr = {pg_tab[pn][ix], off[6:0]};
    endfunction : mem_addr

    function automatic logic [7:0] hdr_byte(input logic [2:0] i, input rx_info_t f,
                                            input logic last, input logic same);
        hdr_byte = 8'h00;
        case (i)
            3'h0:
            begin
                hdr_byte[3:0] = f.ep;
                hdr_byte[HDR_LAST_BIT] = last;
                hdr_byte[HDR_SAME_BIT] = same;
                hdr_byte[HDR_CRC_BIT] = f.crc_bad;
            end
            HDR_FRM_OFF: hdr_byte = f.frame[7:0];
            HDR_FRM_OFF + 3'h1: hdr_byte = {5'h00, f.frame[10:8]};
            HDR_CNT_OFF: hdr_byte = f.count[7:0];
            HDR_CNT_OFF + 3'h1: hdr_byte = {5'h00, f.count[10:8]};
            default: hdr_byte = 8'h00;
        endcase
    endfunction : hdr_byte

    // Bus decode
    logic acc, go, done, wr_done, is_data, mapped, rd_fresh, q_empty;
    logic mcu_we, mcu_we_nx, hdr_we, bacc, rx_we, mem_we;
    logic [2:0] op;
    logic [4:0] cur_pn, head_pn, free_pn, new_pn, pick_pg, need_sel;
    logic [11:0] cur_addr, w_addr, rx_sum;
    logic [7:0] w_data;
    logic [31:0] rdmux, freed;
    logic cmd_alloc, cmd_free, cmd_pop, cmd_popfree, do_free, a_start, a_done, rx_req;

    assign acc = i_psel & i_penable;
    assign is_data = (i_paddr == OFF_DATA);
    assign q_empty = (qh_q == qt_q);
    assign head_pn = rxq[qh_q[4:0]];
    assign cur_pn = sel_head_q ? head_pn : pnr_q;
    // Process form so a page table update also moves the address
    always_comb cur_addr = mem_addr(cur_pn, ptr_q);
    assign rd_fresh = !mem_we_q && (rd_addr_q == cur_addr);
    // Data reads wait for a prefetch of the current byte
    assign go = acc & !pready_q & !(is_data & !i_pwrite & !rd_fresh);
    assign done = acc & pready_q;
    assign wr_done = done & i_pwrite;
    assign mcu_we = wr_done & is_data & !dir_read_q;
    assign mcu_we_nx = go & i_pwrite & is_data & !dir_read_q;
    assign op = i_pwdata[CMD_OP_LSB +: 3];
    assign cmd_alloc = wr_done && i_paddr == OFF_CMD && op == OP_ALLOC;
    assign cmd_free = wr_done && i_paddr == OFF_CMD && op == OP_FREE;
    assign cmd_pop = wr_done && i_paddr == OFF_CMD && op == OP_POP && !q_empty;
    assign cmd_popfree = wr_done && i_paddr == OFF_CMD && op == OP_POPFREE && !q_empty;
    assign do_free = cmd_free | cmd_popfree;
    assign free_pn = cmd_popfree ? head_pn : pnr_q;

    always_comb
    begin
        mapped = 1'b1;
        rdmux = 32'h0000_0000;
        case (i_paddr)
            OFF_CMD: rdmux = 32'h0000_0000;
            OFF_ARR: rdmux = {24'h0, fail_q, 2'b00, arr_pn_q};
            OFF_PNR: rdmux = {27'h0, pnr_q};
            OFF_RXQ: rdmux = {24'h0, q_empty, 2'b00, head_pn};
            OFF_PLO: rdmux = {21'h0, ptr_q};
            OFF_PHI: rdmux = {24'h0, sel_head_q, auto_q, dir_read_q, 2'b00, ptr_q[10:8]};
            OFF_DATA: rdmux = {24'h0, rd_q};
            OFF_MASK: rdmux = {24'h0, mask_q};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= go;
            pslverr_q <= go & !mapped;
            if (go & !i_pwrite)
                prdata_q <= rdmux;
        end
    end

    // Pointer pair: the offset loads when the high half is written and steps on each data access in auto mode
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pnr_q <= 5'd0;
            mask_q <= MASK_RESET;
            plo_q <= 8'h00;
            ptr_q <= 11'h000;
            sel_head_q <= 1'b0;
            auto_q <= 1'b0;
            dir_read_q <= 1'b0;
        end
        else if (wr_done)
        begin
            case (i_paddr)
                OFF_PNR: pnr_q <= i_pwdata[4:0];
                OFF_MASK: mask_q <= i_pwdata[7:0];
                OFF_PLO: plo_q <= i_pwdata[7:0];
                OFF_PHI:
                begin
                    ptr_q <= {i_pwdata[2:0], plo_q};
                    sel_head_q <= i_pwdata[PHI_HEAD_BIT];
                    auto_q <= i_pwdata[PHI_AUTO_BIT];
                    dir_read_q <= i_pwdata[PHI_READ_BIT];
                end
                OFF_DATA:
                    if (auto_q)
                        ptr_q <= ptr_q + 11'h001;
                default: ;
            endcase
        end
        else if (done && is_data && auto_q)
            ptr_q <= ptr_q + 11'h001;
    end

    // Memory port; the bus write owns the cycle, the receiver stalls
    assign hdr_we = (r_state_q == R_HDR) & !mcu_we;
    assign bacc = i_rx_byte_valid & byte_rdy_q;
    assign rx_we = hdr_we | (bacc && r_off_q[10:7] < r_need_q[3:0]);
    assign mem_we = mcu_we | rx_we;
    always_comb
        w_addr = mcu_we ? cur_addr : mem_addr(r_pn_q, hdr_we ? {8'h00, r_idx_q} : r_off_q);
    assign w_data = mcu_we ? i_pwdata[7:0] : (hdr_we ? hdr_byte(r_idx_q, r_info_q, r_last_q, r_same_q)
                                                     : i_rx_byte);

    always_ff @(posedge i_core_clk)
    begin
        if (mem_we)
            mem[w_addr] <= w_data;
        rd_q <= mem[cur_addr];
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rd_addr_q <= 12'h000;
            mem_we_q <= 1'b1;
        end
        else
        begin
            rd_addr_q <= cur_addr;
            // Only a write to the byte being fetched makes the prefetch stale
            mem_we_q <= mem_we && (w_addr == cur_addr);
        end
    end

    // Allocator: one page per cycle once the whole request is known to fit
    assign rx_req = (r_state_q == R_WAIT);
    assign need_sel = rx_req ? r_need_q : mcu_need_q;
    assign new_pn = low_one(~used_q);
    assign pick_pg = low_one(free_q);
    assign a_start = (a_state_q == A_IDLE) && (rx_req || mcu_pend_q) &&
                     ones(free_q) >= {1'b0, need_sel} && used_q != 32'hffff_ffff;
    assign a_done = (a_state_q == A_PICK) && (a_cnt_q == a_need_q - 5'd1);

    always_comb
    begin
        freed = 32'h0000_0000;
        for (int i = 0; i < 10; i++)
        begin
            if (i[4:0] < npg_q[free_pn])
                freed[pg_tab[free_pn][i]] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (a_start)
            npg_q[new_pn] <= need_sel;
        if (a_state_q == A_PICK)
            pg_tab[a_pn_q][a_cnt_q[3:0]] <= pick_pg;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            a_state_q <= A_IDLE;
            a_rx_q <= 1'b0;
            a_need_q <= 5'd1;
            a_cnt_q <= 5'd0;
            a_pn_q <= 5'd0;
            free_q <= 32'hffff_ffff;
            used_q <= 32'h0000_0000;
        end
        else
        begin
            free_q <= (free_q | (do_free && used_q[free_pn] ? freed : 32'h0)) &
                      ~((a_state_q == A_PICK) ? (32'h1 << pick_pg) : 32'h0);
            used_q <= (used_q & ~(do_free ? (32'h1 << free_pn) : 32'h0)) |
                      (a_start ? (32'h1 << new_pn) : 32'h0);
            case (a_state_q)
                A_IDLE:
                    if (a_start)
                    begin
                        a_state_q <= A_PICK;
                        a_rx_q <= rx_req;
                        a_need_q <= need_sel;
                        a_cnt_q <= 5'd0;
                        a_pn_q <= new_pn;
                    end
                A_PICK:
                begin
                    a_cnt_q <= a_cnt_q + 5'd1;
                    if (a_done)
                        a_state_q <= A_IDLE;
                end
                default: a_state_q <= A_IDLE;
            endcase
        end
    end

    // Allocation result seen by software
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fail_q <= ARR_FAIL_RESET;
            mcu_pend_q <= 1'b0;
            mcu_need_q <= 5'd1;
            arr_pn_q <= 5'd0;
        end
        else
        begin
            if (a_done && !a_rx_q)
            begin
                fail_q <= 1'b0;
                arr_pn_q <= a_pn_q;
            end
            if (a_start && !rx_req)
                mcu_pend_q <= 1'b0;
            // A new command wins over a completion in the same cycle
            if (cmd_alloc)
            begin
                fail_q <= 1'b1;
                mcu_pend_q <= 1'b1;
                mcu_need_q <= (i_pwdata[3:0] > 4'd9) ? MAX_PG : {1'b0, i_pwdata[3:0]} + 5'd1;
            end
        end
    end

    // Receive path
    assign rx_sum = {1'b0, i_rx_info.count} + {1'b0, HDR_LEN} + 12'd127;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r_state_q <= R_IDLE;
            r_info_q <= '0;
            r_last_q <= 1'b0;
            r_same_q <= 1'b0;
            tog_q <= 16'h0000;
            r_need_q <= 5'd1;
            r_pn_q <= 5'd0;
            r_idx_q <= 3'd0;
            r_off_q <= 11'h000;
            r_rem_q <= 11'h000;
            rx_rdy_q <= 1'b1;
            byte_rdy_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= (r_state_q == R_PUSH) & !mask_q[0];
            byte_rdy_q <= 1'b0;
            case (r_state_q)
                R_IDLE:
                    if (i_rx_valid)
                    begin
                        r_state_q <= R_WAIT;
                        rx_rdy_q <= 1'b0;
                        r_info_q <= i_rx_info;
                        r_last_q <= tog_q[i_rx_info.ep];
                        r_same_q <= tog_q[i_rx_info.ep] == i_rx_info.toggle;
                        tog_q[i_rx_info.ep] <= i_rx_info.toggle;
                        r_need_q <= (rx_sum[11:7] > MAX_PG) ? MAX_PG : rx_sum[11:7];
                    end
                R_WAIT:
                    if (a_done && a_rx_q)
                    begin
                        r_state_q <= R_HDR;
                        r_pn_q <= a_pn_q;
                        r_idx_q <= 3'd0;
                    end
                R_HDR:
                    if (hdr_we)
                    begin
                        r_idx_q <= r_idx_q + 3'd1;
                        if (r_idx_q == 3'd7)
                        begin
                            r_state_q <= R_DATA;
                            r_off_q <= HDR_LEN;
                            r_rem_q <= r_info_q.count;
                        end
                    end
                R_DATA:
                begin
                    if (bacc)
                    begin
                        r_off_q <= r_off_q + 11'h001;
                        r_rem_q <= r_rem_q - 11'h001;
                    end
                    if (r_rem_q == 11'h000)
                        r_state_q <= R_PUSH;
                    else
                        byte_rdy_q <= !mcu_we_nx && !(bacc && r_rem_q == 11'h001);
                end
                R_PUSH:
                begin
                    r_state_q <= R_IDLE;
                    rx_rdy_q <= 1'b1;
                end
                default: r_state_q <= R_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (r_state_q == R_PUSH)
            rxq[qt_q[4:0]] <= r_pn_q;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            qh_q <= 6'd0;
            qt_q <= 6'd0;
        end
        else
        begin
            if (r_state_q == R_PUSH)
                qt_q <= qt_q + 6'd1;
            if (cmd_pop || cmd_popfree)
                qh_q <= qh_q + 6'd1;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_rx_ready = rx_rdy_q;
    assign o_rx_byte_ready = byte_rdy_q;
    assign o_rx_irq = irq_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    alloc_flag_set_a: assert property (cmd_alloc |=> fail_q)
        else $error("failed flag not set by allocate");
    alloc_fast_a: assert property (a_start && !rx_req |-> ##[1:alloc_lim] (a_done && !a_rx_q))
        else $error("allocation too slow");
    free_handle_a: assert property (cmd_free && used_q[pnr_q] |=> !used_q[$past(pnr_q)])
        else $error("freed handle still in use");
    rx_push_a: assert property (r_state_q == R_PUSH |=> qt_q == $past(qt_q) + 6'd1)
        else $error("reception not queued");
    rx_irq_a: assert property (r_state_q == R_PUSH && !mask_q[0] |=> o_rx_irq)
        else $error("receive interrupt missing");
    empty_flag_a: assert property (go && !i_pwrite && i_paddr == OFF_RXQ |=> o_prdata[RXQ_EMPTY_BIT] == $past(q_empty))
        else $error("empty flag wrong");
    seq_access_a: assert property (acc && is_data && !pready_q |-> ##[0:seq_lim] pready_q)
        else $error("data window access too slow");
    pnr_valid_a: assert property (wr_done && i_paddr == OFF_PNR |-> ##[1:pnr_lim] rd_fresh)
        else $error("read data not valid in time");
    auto_step_a: assert property (done && is_data && auto_q && !i_pwrite |=> ptr_q == $past(ptr_q) + 11'h001)
        else $error("offset did not advance");
    pop_keep_a: assert property (cmd_pop |=> used_q[$past(head_pn)] || $past(a_done))
        else $error("plain pop released memory");
endmodule : packet_memory_manager
`default_nettype wire

// ---- verilog/pbuf_pkg.sv ----
// Constants and types of the packet buffer manager.
// Assumes a 40 MHz core clock and an APB master with 32-bit data.
package pbuf_pkg;
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ARR = 8'h04;
    localparam logic [7:0] OFF_PNR = 8'h08;
    localparam logic [7:0] OFF_RXQ = 8'h0c;
    localparam logic [7:0] OFF_PLO = 8'h10;
    localparam logic [7:0] OFF_PHI = 8'h14;
    localparam logic [7:0] OFF_DATA = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1c;
    localparam logic [2:0] OP_ALLOC = 3'h1;
    localparam logic [2:0] OP_FREE = 3'h2;
    localparam logic [2:0] OP_POP = 3'h4;
    localparam logic [2:0] OP_POPFREE = 3'h5;
    localparam int CMD_OP_LSB = 5;
    localparam int ARR_FAIL_BIT = 7;
    localparam int RXQ_EMPTY_BIT = 7;
    localparam int PHI_HEAD_BIT = 7;
    localparam int PHI_AUTO_BIT = 6;
    localparam int PHI_READ_BIT = 5;
    localparam int HDR_CRC_BIT = 7;
    localparam int HDR_SAME_BIT = 5;
    localparam int HDR_LAST_BIT = 4;
    localparam logic [2:0] HDR_FRM_OFF = 3'h1;
    localparam logic [2:0] HDR_CNT_OFF = 3'h6;
    localparam logic [10:0] HDR_LEN = 11'h008;
    localparam logic [7:0] MASK_RESET = 8'h01;
    localparam logic ARR_FAIL_RESET = 1'b0;
    localparam int PAGES = 32;
    localparam int PAGE_BYTES = 128;
    localparam logic [4:0] MAX_PG = 5'd10;
    localparam int CLK_NS = 25;
    localparam int T_PNR_NS = 1218;
    localparam int T_SEQ_NS = 588;
    localparam int T_ALLOC_NS = 2000;
    localparam int PNR_CYC = T_PNR_NS / CLK_NS;
    localparam int SEQ_CYC = T_SEQ_NS / CLK_NS;
    localparam int ALLOC_CYC = T_ALLOC_NS / CLK_NS;

    typedef struct packed {
        logic [3:0] ep;
        logic toggle;
        logic crc_bad;
        logic [10:0] frame;
        logic [10:0] count;
    } rx_info_t;

    typedef enum logic [1:0] {A_IDLE = 2'b01, A_PICK = 2'b10} alloc_state_t;
    typedef enum logic [4:0] {
        R_IDLE = 5'b00001,
        R_WAIT = 5'b00010,
        R_HDR = 5'b00100,
        R_DATA = 5'b01000,
        R_PUSH = 5'b10000
    } rx_state_t;
endpackage : pbuf_pkg
